/* File: common/dtlb_defs.svh */
`ifndef DTLB_DEFS_SVH
`define DTLB_DEFS_SVH
// ==========================================================
// register map
`define DT_OFF_CR0     12'h000
`define DT_OFF_CR1     12'h004
`define DT_OFF_STAT    12'h008
`define DT_CR0_RST     32'h0000_0000
`define DT_CR1_RST     32'h0000_0000
// ==========================================================
// control and status register fields
`define DT_CR0_PS      23:22
`define DT_CR0_SS      20:19
`define DT_PS_2K       2'h1
`define DT_PS_4K       2'h2
`define DT_SS_64K      2'h0
`define DT_SS_1M       2'h2
`define DT_CR1_STL     31:24
`define DT_CR1_STO     17:0
`define DT_ST_ACT      1:0
`define DT_ST_EXC      3:2
`define DT_ST_VLD      6:4
`define DT_ST_BUSY     7
// ==========================================================
// virtual address fields
`define DT_VA_PN4      23:12
`define DT_VA_PN2      23:11
`define DT_VA_SX64     23:16
`define DT_VA_SX1M     23:20
`define DT_VA_PX64_4   15:12
`define DT_VA_PX64_2   15:11
`define DT_VA_PX1M_4   19:12
`define DT_VA_PX1M_2   19:11
`define DT_VA_D4       11:0
`define DT_VA_D2       10:0
// ==========================================================
// table entry fields
`define DT_SE_PTL      31:28
`define DT_SE_PTO      23:3
`define DT_SE_INV      0
`define DT_PE_FR4      15:4
`define DT_PE_FR2      15:3
`define DT_PE_INV4     3
`define DT_PE_INV2     2
`define DT_HW_SEL      1
`define DT_PE_HI       31:16
`define DT_PE_LO       15:0
`define DT_STO_SHIFT   6
`define DT_SX_SHIFT    2
`define DT_PTO_SHIFT   3
`define DT_PX_SHIFT    1
`define DT_LEN_SHIFT   4
// ==========================================================
// sizes, codes and timing
`define DT_LOCS        64
`define DT_SPACES      3
`define DT_CC_OK       2'h0
`define DT_CC_SEG      2'h1
`define DT_CC_PAGE     2'h2
`define DT_CNT_MAX     255
`define DT_CPU_CYC_NS  115
`define DT_CLK_NS      25
`define DT_MIN_CPU_CYC 6
`define DT_MIN_CYC \
  ((`DT_MIN_CPU_CYC*`DT_CPU_CYC_NS+`DT_CLK_NS-1)/`DT_CLK_NS)
`endif

/* File: common/dtlb_pkg.sv */
package dtlb_pkg;
  typedef enum {DT_IDLE, DT_SEG, DT_PAGE, DT_HOLD} dtlb_state_t;
  typedef enum logic [1:0] {
    DT_EXC_NONE, DT_EXC_SPEC, DT_EXC_SEG, DT_EXC_PAGE
  } dtlb_exc_t;
  typedef struct packed {
    logic [1:0]  code;
    logic [12:0] vpn;
    logic [12:0] frame;
  } dtlb_entry_t;
endpackage : dtlb_pkg

/* File: rtl/dtlb_top.sv */
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "dtlb_defs.svh"
module dtlb_top
  import dtlb_pkg::*;
#(
  parameter int LOCS    = `DT_LOCS,
  parameter int MIN_CYC = `DT_MIN_CYC
) (
  input  wire logic        CLOCK,
  input  wire logic        ARST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        XLAT_REQ,
  input  wire logic        XLAT_EXPLICIT,
  input  wire logic [23:0] XLAT_VADDR,
  output logic             XLAT_BUSY,
  output logic             XLAT_DONE,
  output logic      [23:0] XLAT_RADDR,
  output dtlb_exc_t        XLAT_EXC,
  output logic      [1:0]  XLAT_CC,
  output logic             PROG_INT,
  output logic             MEM_REQ,
  output logic      [23:0] MEM_ADDR,
  input  wire logic        MEM_ACK,
  input  wire logic [31:0] MEM_RDATA,
  input  wire logic        TRANSLATION_CACHE_FLUSH_INSTR,
  input  wire logic        INITIAL_PROGRAM_RESET,
  input  wire logic        PROGRAM_RESET,
  input  wire logic        MACHINE_CHECK,
  input  wire logic        CONSOLE_STORE_STATUS,
  input  wire logic        CONSOLE_ALTER
);
  localparam int          LB    = $clog2(LOCS);
  localparam int          NE    = 2 * LOCS;
  localparam logic [7:0]  MIN_C = 8'(MIN_CYC);
  localparam logic [1:0]  LASTC = 2'(`DT_SPACES);

  generate
    if (LOCS < 2 || LOCS > `DT_LOCS || (1 << LB) != LOCS ||
        MIN_CYC < 1 || MIN_CYC >= `DT_CNT_MAX) begin : g_bad
      $error("dtlb_top: unsupported parameter value");
    end
  endgenerate

  // ==========================================================
  // field decoding
  function automatic logic cr0_ok(input logic [31:0] c);
    return (c[`DT_CR0_PS] == `DT_PS_2K || c[`DT_CR0_PS] == `DT_PS_4K)
        && (c[`DT_CR0_SS] == `DT_SS_64K || c[`DT_CR0_SS] == `DT_SS_1M);
  endfunction : cr0_ok

  function automatic logic is4k(input logic [31:0] c);
    return c[`DT_CR0_PS] == `DT_PS_4K;
  endfunction : is4k

  function automatic logic is1m(input logic [31:0] c);
    return c[`DT_CR0_SS] == `DT_SS_1M;
  endfunction : is1m

  function automatic logic [12:0] vpn_of(input logic [31:0] c,
                                         input logic [23:0] va);
    return is4k(c) ? 13'(va[`DT_VA_PN4]) : va[`DT_VA_PN2];
  endfunction : vpn_of

  function automatic logic [7:0] sx_of(input logic [31:0] c,
                                       input logic [23:0] va);
    return is1m(c) ? 8'(va[`DT_VA_SX1M]) : va[`DT_VA_SX64];
  endfunction : sx_of

  function automatic logic [8:0] px_of(input logic [31:0] c,
                                       input logic [23:0] va);
    if (is1m(c))
      return is4k(c) ? 9'(va[`DT_VA_PX1M_4]) : va[`DT_VA_PX1M_2];
    return is4k(c) ? 9'(va[`DT_VA_PX64_4]) : 9'(va[`DT_VA_PX64_2]);
  endfunction : px_of

  function automatic logic [23:0] mk_radr(input logic [31:0] c,
                                          input logic [12:0] fr,
                                          input logic [23:0] va);
    return is4k(c) ? {12'(fr), va[`DT_VA_D4]} : {fr, va[`DT_VA_D2]};
  endfunction : mk_radr

  function automatic logic mapped(input logic [11:0] a);
    return a == `DT_OFF_CR0 || a == `DT_OFF_CR1 || a == `DT_OFF_STAT;
  endfunction : mapped

  // ==========================================================
  // state
  dtlb_state_t       state;
  dtlb_exc_t         res_exc;
  logic [31:0]       cr0;
  logic [31:0]       cr1;
  logic [23:0]       va_q;
  logic              expl_q;
  logic [7:0]        walk_cnt;
  logic [12:0]       res_frame;
  logic              fill;
  logic              fill_ok;
  logic [1:0]        active_code;
  logic [1:0]        fifo_ptr;
  logic [17:0]       sto_sv [1:`DT_SPACES];
  logic [`DT_SPACES:1] sto_vld;
  logic              seg_sv_vld;
  logic [7:0]        seg_sv_idx;
  logic [17:0]       seg_sv_sto;
  logic [31:0]       seg_sv_ent;
  dtlb_entry_t       tlb [NE];

  logic              apb_wr;
  logic              cr0_wr;
  logic              cr1_wr;
  logic              any_reset;
  logic              flush_all;
  logic [1:0]        match_code;
  logic              disp;
  logic [3:0]        used;
  logic [12:0]       cur_vpn;
  logic [LB:0]       hidx;
  logic              hit_go;
  logic              sv_hit;
  logic              take;
  logic              hold_end;
  logic [31:0]       pg_ent;
  logic [23:0]       pg_va;
  logic              pbad;
  logic [23:0]       paddr;
  logic [15:0]       pe;
  logic              pe_inv;
  logic [12:0]       fvpn;
  logic              fill_go;
  logic [31:0]       stat;

  assign apb_wr    = PSEL && PENABLE && PREADY && PWRITE;
  assign cr0_wr    = apb_wr && PADDR == `DT_OFF_CR0;
  assign cr1_wr    = apb_wr && PADDR == `DT_OFF_CR1;
  assign any_reset = INITIAL_PROGRAM_RESET || PROGRAM_RESET;
  assign flush_all = any_reset || TRANSLATION_CACHE_FLUSH_INSTR
    || MACHINE_CHECK || CONSOLE_STORE_STATUS || CONSOLE_ALTER
    || (cr0_wr && (PWDATA[`DT_CR0_PS] != cr0[`DT_CR0_PS] ||
                   PWDATA[`DT_CR0_SS] != cr0[`DT_CR0_SS]));

  // ==========================================================
  // lookup
  assign cur_vpn = vpn_of(cr0, XLAT_VADDR);
  assign hidx    = cur_vpn[LB:0];
  assign hit_go  = cr0_ok(cr0) && !XLAT_EXPLICIT
    && active_code != 2'h0 && tlb[hidx].code == active_code
    && tlb[hidx].vpn == cur_vpn;
  assign take    = state == DT_IDLE && XLAT_REQ && !hit_go;
  assign sv_hit  = seg_sv_vld && seg_sv_sto == cr1[`DT_CR1_STO]
    && seg_sv_idx == sx_of(cr0, XLAT_VADDR);
  assign hold_end = state == DT_HOLD && walk_cnt >= MIN_C;

  assign pg_ent = state == DT_IDLE ? seg_sv_ent : MEM_RDATA;
  assign pg_va  = state == DT_IDLE ? XLAT_VADDR : va_q;
  assign pbad   = 5'(px_of(cr0, pg_va) >> `DT_LEN_SHIFT) >
                  5'(pg_ent[`DT_SE_PTL]);
  assign paddr  = (24'(pg_ent[`DT_SE_PTO]) << `DT_PTO_SHIFT)
                + (24'(px_of(cr0, pg_va)) << `DT_PX_SHIFT);
  assign pe     = MEM_ADDR[`DT_HW_SEL] ? MEM_RDATA[`DT_PE_LO]
                                       : MEM_RDATA[`DT_PE_HI];
  assign pe_inv = is4k(cr0) ? pe[`DT_PE_INV4] : pe[`DT_PE_INV2];
  assign fvpn   = vpn_of(cr0, va_q);
  assign fill_go = fill && fill_ok && !flush_all && !cr1_wr
                && active_code != 2'h0;

  always_comb begin
    used = 4'h0;
    for (int k = 0; k < NE; k++) begin
      used[tlb[k].code] = 1'b1;
    end
  end

  always_comb begin
    match_code = 2'h0;
    for (int k = 1; k <= `DT_SPACES; k++) begin
      if (sto_vld[k] && sto_sv[k] == PWDATA[`DT_CR1_STO]) begin
        match_code = 2'(k);
      end
    end
  end
  assign disp = cr1_wr && match_code == 2'h0 && sto_vld[fifo_ptr];

  // ==========================================================
  // buffer entries
  generate
    for (genvar i = 0; i < NE; i++) begin : g_ent
      always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
          tlb[i] <= '0;
        end else if (flush_all) begin
          tlb[i].code <= 2'h0;
        end else if (disp && tlb[i].code == fifo_ptr) begin
          tlb[i].code <= 2'h0;
        end else if (fill_go && fvpn[LB:0] == (LB+1)'(i)) begin
          tlb[i] <= '{active_code, fvpn, res_frame};
        end
      end
    end
  endgenerate

  // ==========================================================
  // address spaces
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      active_code <= 2'h0;
      fifo_ptr    <= 2'h1;
      sto_vld     <= '0;
      for (int k = 1; k <= `DT_SPACES; k++) sto_sv[k] <= '0;
    end else if (any_reset) begin
      active_code <= 2'h0;
      fifo_ptr    <= 2'h1;
      sto_vld     <= '0;
    end else if (cr1_wr) begin
      if (match_code != 2'h0) begin
        active_code <= match_code;
      end else begin
        sto_sv[fifo_ptr]  <= PWDATA[`DT_CR1_STO];
        sto_vld[fifo_ptr] <= 1'b1;
        active_code       <= fifo_ptr;
        fifo_ptr <= fifo_ptr == LASTC ? 2'h1 : fifo_ptr + 2'h1;
      end
    end
  end

  // ==========================================================
  // segment entry save area
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      seg_sv_vld <= 1'b0;
      seg_sv_idx <= '0;
      seg_sv_sto <= '0;
      seg_sv_ent <= '0;
    end else if (flush_all) begin
      seg_sv_vld <= 1'b0;
    end else if (state == DT_SEG && MEM_ACK && !MEM_RDATA[`DT_SE_INV]) begin
      seg_sv_vld <= 1'b1;
      seg_sv_idx <= sx_of(cr0, va_q);
      seg_sv_sto <= cr1[`DT_CR1_STO];
      seg_sv_ent <= MEM_RDATA;
    end
  end

  // ==========================================================
  // table walk
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      state     <= DT_IDLE;
      va_q      <= '0;
      expl_q    <= 1'b0;
      walk_cnt  <= '0;
      res_exc   <= DT_EXC_NONE;
      res_frame <= '0;
      fill      <= 1'b0;
      fill_ok   <= 1'b0;
      MEM_REQ   <= 1'b0;
      MEM_ADDR  <= '0;
    end else begin
      fill    <= 1'b0;
      fill_ok <= fill_ok && !flush_all && !cr1_wr;
      if (state != DT_IDLE && walk_cnt != 8'hFF) begin
        walk_cnt <= walk_cnt + 8'h01;
      end
      unique case (state)
        DT_IDLE: if (take) begin
          va_q     <= XLAT_VADDR;
          expl_q   <= XLAT_EXPLICIT;
          walk_cnt <= 8'h01;
          fill_ok  <= !flush_all && !cr1_wr;
          res_exc  <= DT_EXC_NONE;
          state    <= DT_HOLD;
          if (!cr0_ok(cr0)) begin
            res_exc <= DT_EXC_SPEC;
          end else if (8'(sx_of(cr0, XLAT_VADDR) >> `DT_LEN_SHIFT) >
                       cr1[`DT_CR1_STL]) begin
            res_exc <= DT_EXC_SEG;
          end else if (sv_hit) begin
            if (pbad) begin
              res_exc <= DT_EXC_PAGE;
            end else begin
              MEM_REQ  <= 1'b1;
              MEM_ADDR <= paddr;
              state    <= DT_PAGE;
            end
          end else begin
            MEM_REQ  <= 1'b1;
            MEM_ADDR <= (24'(cr1[`DT_CR1_STO]) << `DT_STO_SHIFT)
              + (24'(sx_of(cr0, XLAT_VADDR)) << `DT_SX_SHIFT);
            state    <= DT_SEG;
          end
        end
        DT_SEG: if (MEM_ACK) begin
          MEM_REQ <= 1'b0;
          state   <= DT_HOLD;
          if (MEM_RDATA[`DT_SE_INV]) begin
            res_exc <= DT_EXC_SEG;
          end else if (pbad) begin
            res_exc <= DT_EXC_PAGE;
          end else begin
            MEM_REQ  <= 1'b1;
            MEM_ADDR <= paddr;
            state    <= DT_PAGE;
          end
        end
        DT_PAGE: if (MEM_ACK) begin
          MEM_REQ <= 1'b0;
          state   <= DT_HOLD;
          if (pe_inv) begin
            res_exc <= DT_EXC_PAGE;
          end else begin
            res_frame <= is4k(cr0) ? 13'(pe[`DT_PE_FR4]) : pe[`DT_PE_FR2];
            fill      <= !expl_q;
          end
        end
        DT_HOLD: if (hold_end) state <= DT_IDLE;
      endcase
    end
  end

  // ==========================================================
  // translation answer
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      XLAT_BUSY  <= 1'b0;
      XLAT_DONE  <= 1'b0;
      XLAT_RADDR <= '0;
      XLAT_EXC   <= DT_EXC_NONE;
      XLAT_CC    <= `DT_CC_OK;
      PROG_INT   <= 1'b0;
    end else begin
      XLAT_DONE <= 1'b0;
      PROG_INT  <= 1'b0;
      XLAT_BUSY <= take || (state != DT_IDLE && !hold_end);
      if (state == DT_IDLE && XLAT_REQ && hit_go) begin
        XLAT_DONE  <= 1'b1;
        XLAT_EXC   <= DT_EXC_NONE;
        XLAT_CC    <= `DT_CC_OK;
        XLAT_RADDR <= mk_radr(cr0, tlb[hidx].frame, XLAT_VADDR);
      end else if (hold_end) begin
        XLAT_DONE  <= 1'b1;
        XLAT_EXC   <= res_exc;
        XLAT_RADDR <= res_exc == DT_EXC_NONE ?
                      mk_radr(cr0, res_frame, va_q) : 24'h0;
        XLAT_CC    <= !expl_q ? `DT_CC_OK :
                      res_exc == DT_EXC_SEG  ? `DT_CC_SEG :
                      res_exc == DT_EXC_PAGE ? `DT_CC_PAGE : `DT_CC_OK;
        PROG_INT   <= res_exc != DT_EXC_NONE &&
                      (!expl_q || res_exc == DT_EXC_SPEC);
      end
    end
  end

  // ==========================================================
  // register bus
  always_comb begin
    stat = 32'h0;
    stat[`DT_ST_ACT]  = active_code;
    stat[`DT_ST_EXC]  = XLAT_EXC;
    stat[`DT_ST_VLD]  = sto_vld;
    stat[`DT_ST_BUSY] = XLAT_BUSY;
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= '0;
      cr0     <= `DT_CR0_RST;
      cr1     <= `DT_CR1_RST;
    end else begin
      PREADY <= PSEL && !PENABLE;
      if (PSEL && !PENABLE) begin
        PSLVERR <= !mapped(PADDR);
        PRDATA  <= PADDR == `DT_OFF_CR0  ? cr0 :
                   PADDR == `DT_OFF_CR1  ? cr1 :
                   PADDR == `DT_OFF_STAT ? stat : 32'h0;
      end
      if (cr0_wr) cr0 <= PWDATA;
      if (cr1_wr) cr1 <= PWDATA;
    end
  end

  // ==========================================================
  // checks
  property p_flush;
    @(posedge CLOCK) disable iff (!ARST_N)
    TRANSLATION_CACHE_FLUSH_INSTR |=> used[3:1] == 3'h0 && !seg_sv_vld;
  endproperty
  a_flush: assert property (p_flush) else $error("flush left entries");

  property p_reset;
    @(posedge CLOCK) disable iff (!ARST_N)
    any_reset |=> used[3:1] == 3'h0 && !seg_sv_vld && active_code == 2'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("reset left entries");

  property p_size;
    @(posedge CLOCK) disable iff (!ARST_N)
    cr0_wr && PWDATA[`DT_CR0_PS] != cr0[`DT_CR0_PS] |=> used[3:1] == 3'h0;
  endproperty
  a_size: assert property (p_size) else $error("size change kept");

  property p_hit;
    @(posedge CLOCK) disable iff (!ARST_N)
    state == DT_IDLE && XLAT_REQ && hit_go |=>
      XLAT_DONE && XLAT_EXC == DT_EXC_NONE && !XLAT_BUSY && !MEM_REQ;
  endproperty
  a_hit: assert property (p_hit) else $error("hit not immediate");

  property p_spec;
    @(posedge CLOCK) disable iff (!ARST_N)
    state == DT_IDLE && XLAT_REQ && !cr0_ok(cr0) |=>
      state == DT_HOLD && res_exc == DT_EXC_SPEC && !MEM_REQ;
  endproperty
  a_spec: assert property (p_spec) else $error("spec not flagged");

  property p_minlat;
    @(posedge CLOCK) disable iff (!ARST_N)
    XLAT_DONE && $past(state) == DT_HOLD |-> walk_cnt > MIN_C;
  endproperty
  a_minlat: assert property (p_minlat) else $error("walk too short");

  property p_int;
    @(posedge CLOCK) disable iff (!ARST_N)
    XLAT_DONE && !expl_q && XLAT_EXC != DT_EXC_NONE |-> PROG_INT;
  endproperty
  a_int: assert property (p_int) else $error("no interrupt");

  property p_lra;
    @(posedge CLOCK) disable iff (!ARST_N)
    XLAT_DONE && expl_q && XLAT_EXC == DT_EXC_SEG |->
      !PROG_INT && XLAT_CC == `DT_CC_SEG;
  endproperty
  a_lra: assert property (p_lra) else $error("explicit cc wrong");

  property p_match;
    @(posedge CLOCK) disable iff (!ARST_N)
    cr1_wr && match_code != 2'h0 && !flush_all |=>
      active_code == $past(match_code) && used == $past(used);
  endproperty
  a_match: assert property (p_match) else $error("known origin");

  property p_disp;
    @(posedge CLOCK) disable iff (!ARST_N)
    disp && !any_reset |=>
      !used[$past(fifo_ptr)] && active_code == $past(fifo_ptr);
  endproperty
  a_disp: assert property (p_disp) else $error("displaced code");

  property p_save;
    @(posedge CLOCK) disable iff (!ARST_N)
    state == DT_IDLE ##1 state == DT_PAGE |-> $past(sv_hit);
  endproperty
  a_save: assert property (p_save) else $error("bad segment skip");
endmodule : dtlb_top

/* File: tb/dtlb_mem.sv */
`timescale 1ns/1ps
module dtlb_mem (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic [3:0]  lat,
  input  wire logic        req,
  input  wire logic [23:0] addr,
  output logic             ack,
  output logic      [31:0] rdata,
  output logic      [7:0]  reads
);
  logic [3:0] cnt;
  // ==========================================
  // tables: segment entries below 0x800, pages above
  function automatic logic [15:0] pte(input logic [7:0] i);
    return {4'hA, i, 1'(i[3:0] == 4'h7), 3'h0};
  endfunction : pte
  function automatic logic [31:0] word(input logic [23:0] a);
    if (a[11])
      return {pte({a[8:2], 1'h0}), pte({a[8:2], 1'h1})};
    return {20'h0, 1'h1, 2'h0, a[5:2], 4'h0, 1'(a[5:2] == 4'h3)};
  endfunction : word
  // released data lines toggle so stale data never stays steady
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      {ack, rdata, cnt, reads} <= '0;
    end else if (req && !ack && cnt >= lat) begin
      ack   <= 1'h1;
      rdata <= word(addr);
      cnt   <= 4'h0;
      reads <= reads + 8'h1;
    end else begin
      ack   <= 1'h0;
      rdata <= ~rdata;
      cnt   <= req ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule : dtlb_mem

/* File: tb/dtlb_top_test.sv */
`timescale 1ns/1ps
module dtlb_top_test
  import dtlb_pkg::*; ;
  localparam int MC = 8;
  // walk answer comes one edge after the walk counter reaches MC
  localparam int WC = MC + 1;
  logic        clock, arst_n, psel, penable, pwrite, xreq, xexp, err;
  logic        pready, pslverr, busy, done, pint_o, mreq, mack, pint;
  logic        bz, bd;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, mdata, rd;
  logic [23:0] xva, raddr, maddr, ra;
  logic [5:0]  ev;
  logic [3:0]  lat;
  logic [1:0]  cc_o, cc, ex;
  logic [7:0]  reads, r0;
  dtlb_exc_t   exc_o;
  int          num_errors = 0, num_checks = 0, cyc = 0, n;
  // ==========================================
  // design and storage partner
  dtlb_top #(.MIN_CYC(MC)) dtlb_top_inst (
    .CLOCK(clock), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .XLAT_REQ(xreq),
    .XLAT_EXPLICIT(xexp), .XLAT_VADDR(xva), .XLAT_BUSY(busy),
    .XLAT_DONE(done), .XLAT_RADDR(raddr), .XLAT_EXC(exc_o),
    .XLAT_CC(cc_o), .PROG_INT(pint_o), .MEM_REQ(mreq),
    .MEM_ADDR(maddr), .MEM_ACK(mack), .MEM_RDATA(mdata),
    .TRANSLATION_CACHE_FLUSH_INSTR(ev[0]), .INITIAL_PROGRAM_RESET(ev[1]),
    .PROGRAM_RESET(ev[2]), .MACHINE_CHECK(ev[3]),
    .CONSOLE_STORE_STATUS(ev[4]), .CONSOLE_ALTER(ev[5])
  );
  dtlb_mem dtlb_mem_inst (
    .clock(clock), .arst_n(arst_n), .lat(lat), .req(mreq), .addr(maddr),
    .ack(mack), .rdata(mdata), .reads(reads)
  );
  initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  task automatic results();
    if (num_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge clock);
    penable <= 1'h1;
    @(posedge clock);
    while (pready !== 1'h1) begin
      @(posedge clock);
    end
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
  endtask : apb
  task automatic xlat(input logic [23:0] va, input logic e);
    @(posedge clock);
    {xreq, xva, xexp} <= {1'h1, va, e};
    @(posedge clock);
    xreq <= 1'h0;
    #1;
    n = 1;
    bz = busy;
    while (done !== 1'h1) begin
      @(posedge clock);
      #1;
      n++;
    end
    {ra, ex, cc, pint, bd} = {raddr, exc_o, cc_o, pint_o, busy};
  endtask : xlat
  task automatic walk(input logic [23:0] va, input int en, input int er);
    r0 = reads;
    xlat(va, 1'h0);
    chk(32'(n), 32'(en));
    chk({30'h0, bz, bd}, {30'h0, 1'(en != 1), 1'h0});
    chk({8'h0, ra}, {12'h0A, va[19:0]});
    if (er >= 0)
      chk(32'(reads - r0), 32'(er));
  endtask : walk
  task automatic pulse(input int i);
    @(posedge clock);
    ev[i] <= 1'h1;
    @(posedge clock);
    ev[i] <= 1'h0;
  endtask : pulse
  task automatic cr1(input logic [31:0] d, input logic [1:0] code);
    apb(1'h1, 12'h004, d);
    apb(1'h0, 12'h008, 32'h0);
    chk({30'h0, rd[1:0]}, {30'h0, code});
  endtask : cr1
  // ==========================================
  // main sequence
  initial begin
    {psel, penable, pwrite, xreq, xexp, arst_n} = 6'h0;
    {paddr, pwdata, xva, ev, lat} = '0;
    repeat (5) @(posedge clock);
    arst_n <= 1'h1;
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 12'h00C, 32'h0);
    chk({rd[31:1], err}, 32'h1);
    apb(1'h1, 12'h000, 32'h0080_0000);
    cr1(32'h1, 2'h1);
    walk(24'h012345, WC, 2);
    walk(24'h012345, 1, 0);
    walk(24'h013345, WC, 1);
    walk(24'h012345, 1, 0);
    walk(24'h092345, WC, 2);
    xlat(24'h030000, 1'h0);
    chk({5'h0, pint, ex, ra}, {6'h01, DT_EXC_SEG, 24'h0});
    xlat(24'h030000, 1'h1);
    chk({5'h0, pint, cc, 24'h0}, {6'h00, 2'h1, 24'h0});
    xlat(24'h017000, 1'h0);
    chk(32'({pint, ex}), 32'({1'h1, DT_EXC_PAGE}));
    xlat(24'h017000, 1'h1);
    chk(32'({pint, cc}), 32'h2);
    r0 = reads;
    xlat(24'h100000, 1'h0);
    chk({pint, ex, reads - r0}, {1'h1, DT_EXC_SEG, 8'h0});
    lat <= 4'h9;
    xlat(24'h0A1000, 1'h0);
    chk({ra, 8'(n > MC)}, {24'hAA1000, 8'h1});
    lat <= 4'h0;
    for (int i = 0; i < 2; i++) begin
      apb(1'h1, 12'h000, (i == 0) ? 32'h00C0_0000 : 32'h0088_0000);
      xlat(24'h012345, 1'h0);
      chk(32'({pint, ex}), 32'({1'h1, DT_EXC_SPEC}));
    end
    // 2K pages with 64K segments, then 4K pages with 1M segments
    apb(1'h1, 12'h000, 32'h0040_0000);
    xlat(24'h012345, 1'h0);
    chk({8'h0, ra}, 32'h00A1_4345);
    apb(1'h1, 12'h000, 32'h0090_0000);
    xlat(24'h10A345, 1'h0);
    chk({8'h0, ra}, 32'h00A1_A345);
    apb(1'h1, 12'h000, 32'h0080_0000);
    for (int i = 0; i < 6; i++) begin
      xlat(24'h012345, 1'h0);
      pulse(i);
      cr1(32'h1, 2'h1);
      walk(24'h012345, WC, 2);
    end
    cr1(32'h2, 2'h2);
    walk(24'h024345, WC, -1);
    cr1(32'h1, 2'h1);
    walk(24'h012345, 1, 0);
    cr1(32'h3, 2'h3);
    walk(24'h012345, WC, -1);
    cr1(32'h4, 2'h1);
    cr1(32'h2, 2'h2);
    walk(24'h024345, 1, 0);
    cr1(32'h1, 2'h2);
    walk(24'h024345, WC, -1);
    results();
  end
endmodule : dtlb_top_test
